/* logic/rcr_pkg.sv */
// Shared constants and carrier types of the reset cause recorder.
// Assumes a 24-bit program counter and a 32-bit AXI4-Lite register bus.
package rcr_pkg;
   localparam int PC_W = 24;
   localparam int FLAG_W = 16;
   // Resume addresses
   localparam logic [23:0] PC_RESET_VEC = 24'h000000;
   localparam logic [23:0] PC_CLKFAIL_VEC = 24'h000004;
   localparam logic [23:0] PC_NEXT_STEP = 24'h000002;
   // Default cause flag positions; brownout is fixed at bit one
   localparam int POS_POWER_ON = 0;
   localparam int POS_BROWNOUT = 1;
   localparam int POS_IDLE = 2;
   localparam int POS_SLEEP = 3;
   localparam int POS_WATCHDOG = 4;
   localparam int POS_SOFTWARE = 6;
   localparam int POS_EXT_PIN = 7;
   localparam int POS_ILLEGAL = 14;
   localparam int POS_TRAP = 15;
   localparam logic [15:0] FLAGS_RESET = 16'h0000;
   // Register byte addresses
   localparam logic [11:0] OFS_CAUSE = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_PC = 12'h008;
   localparam logic [11:0] OFS_CONTROL = 12'h00c;
   localparam int CTRL_SW_RESET_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Event strobes, one cycle each
   typedef struct packed {
      logic power_on;
      logic brownout;
      logic ext_pin;
      logic software;
      logic watchdog;
      logic trap_conflict;
      logic illegal_op;
      logic clock_fail;
      logic irq_wake;
   } rcr_events_t;

   typedef enum logic [3:0] {
      CAUSE_NONE,
      CAUSE_POWER_ON,
      CAUSE_BROWNOUT,
      CAUSE_EXT_RUN,
      CAUSE_EXT_SLEEP,
      CAUSE_EXT_IDLE,
      CAUSE_WDT_RESET,
      CAUSE_WDT_WAKE,
      CAUSE_TRAP,
      CAUSE_ILLEGAL,
      CAUSE_SOFTWARE,
      CAUSE_CLK_FAIL,
      CAUSE_IRQ_WAKE
   } rcr_cause_t;

   typedef struct packed {
      logic pc_load;
      logic [23:0] pc;
      logic [15:0] flags;
   } rcr_result_t;
endpackage : rcr_pkg

/* logic/rcr_event_arbiter.sv */
// Picks the one event that wins when several strobes coincide.
// Assumes strobes and power state inputs are on the same clock.
`timescale 1ns/100ps
module rcr_event_arbiter
   import rcr_pkg::*;
(
   input rcr_events_t events,
   input logic cpu_sleeping,
   input logic cpu_idling,
   output rcr_cause_t cause
);
   // Fixed precedence: power-on, brownout, pin, watchdog, trap, illegal, software, clock failure, interrupt wake
   always_comb
   begin
      if (events.power_on)
         cause = CAUSE_POWER_ON;
      else if (events.brownout)
         cause = CAUSE_BROWNOUT;
      else if (events.ext_pin)
         cause = cpu_sleeping ? CAUSE_EXT_SLEEP :
                 cpu_idling ? CAUSE_EXT_IDLE : CAUSE_EXT_RUN;
      else if (events.watchdog)
         cause = cpu_sleeping ? CAUSE_WDT_WAKE : CAUSE_WDT_RESET;
      else if (events.trap_conflict)
         cause = CAUSE_TRAP;
      else if (events.illegal_op)
         cause = CAUSE_ILLEGAL;
      else if (events.software)
         cause = CAUSE_SOFTWARE;
      else if (events.clock_fail)
         cause = CAUSE_CLK_FAIL;
      else if (events.irq_wake && cpu_sleeping)
         cause = CAUSE_IRQ_WAKE;
      else
         cause = CAUSE_NONE;
   end
endmodule : rcr_event_arbiter

/* logic/rcr_flag_engine.sv */
// Next cause flags and resume address for one chosen event.
// Assumes flags_in already holds any software write of this cycle.
`timescale 1ns/100ps
module rcr_flag_engine
   import rcr_pkg::*;
#(
   parameter int POWER_ON_POS = POS_POWER_ON,
   parameter int IDLE_POS = POS_IDLE,
   parameter int SLEEP_POS = POS_SLEEP,
   parameter int WATCHDOG_POS = POS_WATCHDOG,
   parameter int SOFTWARE_POS = POS_SOFTWARE,
   parameter int EXT_PIN_POS = POS_EXT_PIN,
   parameter int ILLEGAL_POS = POS_ILLEGAL,
   parameter int TRAP_POS = POS_TRAP
)
(
   input rcr_cause_t cause,
   input logic [FLAG_W-1:0] flags_in,
   input logic [PC_W-1:0] cur_pc,
   input logic irq_enabled,
   input logic [PC_W-1:0] irq_vector,
   output rcr_result_t result
);
   logic [FLAG_W-1:0] f;

   // Flags not named by the event keep their value, except on power-on, which clears all others
   always_comb
   begin
      f = flags_in;
      result.pc_load = 1'b1;
      result.pc = PC_RESET_VEC;
      unique case (cause)
         CAUSE_POWER_ON:
         begin
            f = '0;
            f[POWER_ON_POS] = 1'b1;
            f[POS_BROWNOUT] = 1'b1;
         end
         CAUSE_BROWNOUT:
         begin
            f[POS_BROWNOUT] = 1'b1;
            f[POWER_ON_POS] = 1'b0;
         end
         CAUSE_EXT_RUN, CAUSE_SOFTWARE, CAUSE_WDT_RESET:
         begin
            f[EXT_PIN_POS] = (cause == CAUSE_EXT_RUN);
            f[SOFTWARE_POS] = (cause == CAUSE_SOFTWARE);
            f[WATCHDOG_POS] = (cause == CAUSE_WDT_RESET);
            f[IDLE_POS] = 1'b0;
            f[SLEEP_POS] = 1'b0;
         end
         CAUSE_EXT_SLEEP, CAUSE_EXT_IDLE:
         begin
            f[EXT_PIN_POS] = 1'b1;
            f[WATCHDOG_POS] = 1'b0;
            f[SLEEP_POS] = (cause == CAUSE_EXT_SLEEP);
            f[IDLE_POS] = (cause == CAUSE_EXT_IDLE);
         end
         CAUSE_WDT_WAKE:
         begin
            result.pc = PC_W'(cur_pc + PC_NEXT_STEP);
            f[WATCHDOG_POS] = 1'b1;
            f[SLEEP_POS] = 1'b1;
         end
         CAUSE_IRQ_WAKE:
         begin
            f[SLEEP_POS] = 1'b1;
            result.pc = irq_enabled ? irq_vector :
                        PC_W'(cur_pc + PC_NEXT_STEP);
         end
         CAUSE_CLK_FAIL:
            result.pc = PC_CLKFAIL_VEC;
         CAUSE_TRAP:
            f[TRAP_POS] = 1'b1;
         CAUSE_ILLEGAL:
            f[ILLEGAL_POS] = 1'b1;
         CAUSE_NONE:
         begin
            result.pc_load = 1'b0;
            result.pc = cur_pc;
         end
         default:
         begin
            result.pc_load = 1'b0;
            result.pc = cur_pc;
         end
      endcase
      result.flags = f;
   end
endmodule : rcr_flag_engine

/* logic/rcr_reset_cause_recorder.sv */
// Reset cause recorder: cause flags, resume address, AXI4-Lite regs.
// Assumes event strobes come from logic on aclk, one cycle each.
// Function
// - Power-on: pc zero, set power-on and brownout
// - Brownout: pc zero, set brownout, clear power-on
// - Pin reset running: set pin, clear four
// - Software reset: set software, clear four others
// - Pin reset asleep: set pin and sleep
// - Pin reset idle: set pin and idle
// - Watchdog reset: set watchdog, clear four others
// - Watchdog wake: pc plus two, watchdog, sleep
// - Interrupt wake: sleep flag, vector or pc+2
// - Clock failure: trap address, flags untouched
// - Trap conflict: pc zero, set its flag
// - Illegal operation: pc zero, set its flag
// - Software reads and writes every cause flag
// - Brownout flag sits at bit one
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module rcr_reset_cause_recorder
   import rcr_pkg::*;
#(
   parameter int POWER_ON_POS = POS_POWER_ON,
   parameter int IDLE_POS = POS_IDLE,
   parameter int SLEEP_POS = POS_SLEEP,
   parameter int WATCHDOG_POS = POS_WATCHDOG,
   parameter int SOFTWARE_POS = POS_SOFTWARE,
   parameter int EXT_PIN_POS = POS_EXT_PIN,
   parameter int ILLEGAL_POS = POS_ILLEGAL,
   parameter int TRAP_POS = POS_TRAP
)
(
   input logic aclk,
   input logic aresetn,
   input logic [11:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [11:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   input rcr_events_t events,
   input logic cpu_sleeping,
   input logic cpu_idling,
   input logic irq_enabled,
   input logic [PC_W-1:0] irq_vector,
   input logic [PC_W-1:0] cur_pc,
   output logic pc_load,
   output logic [PC_W-1:0] pc_value,
   output logic [FLAG_W-1:0] reset_cause_control
);
   localparam logic [FLAG_W-1:0] POR_SET =
      FLAG_W'((32'h1 << POWER_ON_POS) | (32'h1 << POS_BROWNOUT));

   rcr_events_t events_all;
   rcr_cause_t cause;
   rcr_result_t result;
   rcr_cause_t last_cause_r;
   logic [FLAG_W-1:0] flags_r;
   logic [FLAG_W-1:0] base_flags;
   logic [PC_W-1:0] pc_r;
   logic pc_load_r;
   logic sw_req_r;
   logic aw_have_r;
   logic [11:0] awaddr_r;
   logic w_have_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic do_write;
   logic wr_mapped;
   logic wr_flags;
   logic wr_control;
   logic [31:0] rd_word;
   logic rd_ok;

   // Write channels are taken in either order, one write at a time
   assign s_axi_awready = !aw_have_r && !bvalid_r;
   assign s_axi_wready = !w_have_r && !bvalid_r;
   assign do_write = aw_have_r && w_have_r && !bvalid_r;
   assign wr_flags = do_write && (awaddr_r == OFS_CAUSE);
   assign wr_control = do_write && (awaddr_r == OFS_CONTROL);
   assign wr_mapped = (awaddr_r == OFS_CAUSE) ||
                      (awaddr_r == OFS_STATUS) ||
                      (awaddr_r == OFS_PC) ||
                      (awaddr_r == OFS_CONTROL);

   // Address latch
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_r <= 1'b0;
         awaddr_r <= 12'h000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
      else if (do_write)
         aw_have_r <= 1'b0;
   end

   // Data latch
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_have_r <= 1'b0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
      else if (do_write)
         w_have_r <= 1'b0;
   end

   // Write response, error for unmapped addresses
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
         bvalid_r <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Software reset request, self-clearing after one cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sw_req_r <= 1'b0;
      else
         sw_req_r <= wr_control && wstrb_r[0] &&
                     wdata_r[CTRL_SW_RESET_BIT];
   end

   // Register command joins the hardware strobe
   always_comb
   begin
      events_all = events;
      events_all.software = events.software | sw_req_r;
   end

   // Software write merged first so the event bits win
   always_comb
   begin
      base_flags = flags_r;
      if (wr_flags)
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (wstrb_r[i])
               base_flags[i*8 +: 8] = wdata_r[i*8 +: 8];
         end
      end
   end

   // One winner among coinciding events
   rcr_event_arbiter u_arbiter (
      .events (events_all),
      .cpu_sleeping (cpu_sleeping),
      .cpu_idling (cpu_idling),
      .cause (cause)
   );

   rcr_flag_engine #(
      .POWER_ON_POS (POWER_ON_POS),
      .IDLE_POS (IDLE_POS),
      .SLEEP_POS (SLEEP_POS),
      .WATCHDOG_POS (WATCHDOG_POS),
      .SOFTWARE_POS (SOFTWARE_POS),
      .EXT_PIN_POS (EXT_PIN_POS),
      .ILLEGAL_POS (ILLEGAL_POS),
      .TRAP_POS (TRAP_POS)
   ) u_engine (
      .cause (cause),
      .flags_in (base_flags),
      .cur_pc (cur_pc),
      .irq_enabled (irq_enabled),
      .irq_vector (irq_vector),
      .result (result)
   );

   // Cause flags
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_r <= FLAGS_RESET;
      else
         flags_r <= result.flags;
   end

   // Resume address and its load strobe
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pc_r <= PC_RESET_VEC;
         pc_load_r <= 1'b0;
      end
      else
      begin
         pc_load_r <= result.pc_load;
         if (result.pc_load)
            pc_r <= result.pc;
      end
   end

   // Last event seen, for status reads
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         last_cause_r <= CAUSE_NONE;
      else if (cause != CAUSE_NONE)
         last_cause_r <= cause;
   end

   assign pc_load = pc_load_r;
   assign pc_value = pc_r;
   assign reset_cause_control = flags_r;

   // Read decode
   always_comb
   begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         OFS_CAUSE: rd_word = {16'h0000, flags_r};
         OFS_STATUS: rd_word = {28'h0000000, last_cause_r};
         OFS_PC: rd_word = {8'h00, pc_r};
         OFS_CONTROL: rd_word = {31'h00000000, sw_req_r};
         default:
         begin
            rd_word = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end

   // Read channel, answer one cycle after the address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
         rvalid_r <= 1'b0;
   end

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Checks on recorded causes and bus answers
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_reset_done;
      pc_load_r && (pc_r == PC_RESET_VEC);
   endsequence

   property p_por;
      cause == CAUSE_POWER_ON |=> s_reset_done and
         (flags_r == POR_SET);
   endproperty
   a_por: assert property (p_por)
      else $error("power-on did not load zero and both flags");

   property p_bor;
      cause == CAUSE_BROWNOUT |=> s_reset_done and
         (flags_r[1] && !flags_r[POWER_ON_POS] &&
          flags_r[TRAP_POS] == $past(base_flags[TRAP_POS]));
   endproperty
   a_bor: assert property (p_bor)
      else $error("brownout flags or address wrong");

   property p_ext_run;
      cause == CAUSE_EXT_RUN |=> s_reset_done and
         (flags_r[EXT_PIN_POS] && !flags_r[SOFTWARE_POS] &&
          !flags_r[SLEEP_POS] &&
          flags_r[POWER_ON_POS] == $past(base_flags[POWER_ON_POS]));
   endproperty
   a_ext_run: assert property (p_ext_run)
      else $error("pin reset while running recorded wrongly");

   property p_ext_sleep;
      cause == CAUSE_EXT_SLEEP |=> s_reset_done and
         (flags_r[EXT_PIN_POS] && flags_r[SLEEP_POS] &&
          !flags_r[IDLE_POS] && !flags_r[WATCHDOG_POS]);
   endproperty
   a_ext_sleep: assert property (p_ext_sleep)
      else $error("pin reset in sleep recorded wrongly");

   property p_wdt_reset;
      cause == CAUSE_WDT_RESET |=> s_reset_done and
         (flags_r[WATCHDOG_POS] && !flags_r[EXT_PIN_POS] &&
          !flags_r[IDLE_POS]);
   endproperty
   a_wdt_reset: assert property (p_wdt_reset)
      else $error("watchdog reset recorded wrongly");

   property p_wdt_wake;
      cause == CAUSE_WDT_WAKE |=> pc_load_r &&
         (pc_r == PC_W'($past(cur_pc) + 24'h000002)) &&
         flags_r[WATCHDOG_POS] && flags_r[SLEEP_POS];
   endproperty
   a_wdt_wake: assert property (p_wdt_wake)
      else $error("watchdog wake did not step two on");

   property p_irq_wake;
      cause == CAUSE_IRQ_WAKE |=> flags_r[SLEEP_POS] &&
         (pc_r == ($past(irq_enabled) ? $past(irq_vector) :
                   PC_W'($past(cur_pc) + 24'h000002)));
   endproperty
   a_irq_wake: assert property (p_irq_wake)
      else $error("interrupt wake address or flag wrong");

   property p_clk_fail;
      cause == CAUSE_CLK_FAIL |=> pc_load_r &&
         (pc_r == 24'h000004) && (flags_r == $past(base_flags));
   endproperty
   a_clk_fail: assert property (p_clk_fail)
      else $error("clock failure touched flags or wrong address");

   // Each trap sets only its own flag, the other one keeps its value
   property p_traps;
      (cause == CAUSE_TRAP) || (cause == CAUSE_ILLEGAL) |=>
         s_reset_done and
         (flags_r[TRAP_POS] ==
             ($past(cause == CAUSE_TRAP) || $past(base_flags[TRAP_POS])) &&
          flags_r[ILLEGAL_POS] ==
             ($past(cause == CAUSE_ILLEGAL) ||
              $past(base_flags[ILLEGAL_POS])));
   endproperty
   a_traps: assert property (p_traps)
      else $error("trap reset did not record its flag");

   property p_sw_write;
      wr_flags && (wstrb_r[1:0] == 2'h3) && (cause == CAUSE_NONE) |=>
         flags_r == $past(wdata_r[15:0]);
   endproperty
   a_sw_write: assert property (p_sw_write)
      else $error("software write to flags not stored");

   property p_precedence;
      events.power_on && events.watchdog |=>
         !flags_r[WATCHDOG_POS] && flags_r[POWER_ON_POS];
   endproperty
   a_precedence: assert property (p_precedence)
      else $error("lower event overrode power-on");

   property p_bresp_hold;
      s_axi_bvalid && !s_axi_bready |=>
         s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold)
      else $error("write response dropped before taken");
endmodule : rcr_reset_cause_recorder

/* tb/tb_rcr_reset_cause_recorder.sv */
// Self-checking bench of the reset cause recorder.
// Assumes rcr_pkg and the design files are compiled before it.
`timescale 1ns/100ps
module tb_rcr_reset_cause_recorder
   import rcr_pkg::*;
   ;
   logic aclk;
   logic aresetn;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   rcr_events_t events;
   logic cpu_sleeping, cpu_idling, irq_enabled, pc_load;
   logic [PC_W-1:0] irq_vector, cur_pc, pc_value, exp_pc;
   logic [FLAG_W-1:0] reset_cause_control;
   int num_errors = 0;
   int checks_done = 0;
   integer seed = 14;

   rcr_reset_cause_recorder i_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .events, .cpu_sleeping, .cpu_idling,
      .irq_enabled, .irq_vector, .cur_pc, .pc_load, .pc_value,
      .reset_cause_control
   );

   // Free-running 50 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Verdict and end of run
   task automatic results();
      $display("Compared %0d, mismatched %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   // Word comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Single-bit comparison
   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t bit got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   // Bounds every handshake wait
   task automatic guard(inout int n);
      n++;
      if (n > 100)
      begin
         num_errors++;
         $display("ERROR t=%0t bus stall got=%h exp=%h", $time, 0, 1);
         results();
      end
   endtask : guard

   // AXI4-Lite write; address and data offered together
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
      logic aw_hit, w_hit, aw_done, w_done, hit;
      int n;
      n = 0;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(negedge aclk);
         aw_hit = s_axi_awvalid && s_axi_awready;
         w_hit = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (aw_hit)
            s_axi_awvalid <= 1'b0;
         if (w_hit)
            s_axi_wvalid <= 1'b0;
         aw_done |= aw_hit;
         w_done |= w_hit;
         guard(n);
      end
      do
      begin
         @(negedge aclk);
         hit = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         guard(n);
      end while (!hit);
      s_axi_bready <= 1'b0;
   endtask : axi_write

   // AXI4-Lite read
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic hit;
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         hit = s_axi_arready;
         @(posedge aclk);
         guard(n);
      end while (!hit);
      s_axi_arvalid <= 1'b0;
      do
      begin
         @(negedge aclk);
         hit = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         guard(n);
      end while (!hit);
      s_axi_rready <= 1'b0;
   endtask : axi_read

   // Flags set (upper half) and cleared (lower half) by each cause
   function automatic logic [31:0] masks(input rcr_cause_t c);
      logic [15:0] po, bo, id, sl, wd, sw, ex, il, tr;
      po = 16'h0001 << POS_POWER_ON;
      bo = 16'h0001 << POS_BROWNOUT;
      id = 16'h0001 << POS_IDLE;
      sl = 16'h0001 << POS_SLEEP;
      wd = 16'h0001 << POS_WATCHDOG;
      sw = 16'h0001 << POS_SOFTWARE;
      ex = 16'h0001 << POS_EXT_PIN;
      il = 16'h0001 << POS_ILLEGAL;
      tr = 16'h0001 << POS_TRAP;
      case (c)
         CAUSE_POWER_ON: return {po | bo, 16'hffff};
         CAUSE_BROWNOUT: return {bo, po};
         CAUSE_EXT_RUN: return {ex, sw | wd | id | sl};
         CAUSE_SOFTWARE: return {sw, ex | wd | id | sl};
         CAUSE_EXT_SLEEP: return {ex | sl, wd | id};
         CAUSE_EXT_IDLE: return {ex | id, wd | sl};
         CAUSE_WDT_RESET: return {wd, ex | sw | id | sl};
         CAUSE_WDT_WAKE: return {wd | sl, 16'h0000};
         CAUSE_IRQ_WAKE: return {sl, 16'h0000};
         CAUSE_TRAP: return {tr, 16'h0000};
         CAUSE_ILLEGAL: return {il, 16'h0000};
         default: return 32'h0000_0000;
      endcase
   endfunction : masks

   // Strobe that raises each cause
   function automatic rcr_events_t ev_of(input rcr_cause_t c);
      rcr_events_t e;
      e = '0;
      case (c)
         CAUSE_POWER_ON: e.power_on = 1'b1;
         CAUSE_BROWNOUT: e.brownout = 1'b1;
         CAUSE_EXT_RUN, CAUSE_EXT_SLEEP, CAUSE_EXT_IDLE: e.ext_pin = 1'b1;
         CAUSE_WDT_RESET, CAUSE_WDT_WAKE: e.watchdog = 1'b1;
         CAUSE_TRAP: e.trap_conflict = 1'b1;
         CAUSE_ILLEGAL: e.illegal_op = 1'b1;
         CAUSE_SOFTWARE: e.software = 1'b1;
         CAUSE_CLK_FAIL: e.clock_fail = 1'b1;
         CAUSE_IRQ_WAKE: e.irq_wake = 1'b1;
         default: e = '0;
      endcase
      return e;
   endfunction : ev_of

   // One event on random flags, optionally with lower strobes beside it
   task automatic run_case(input rcr_cause_t c, input bit noisy);
      logic [31:0] mk, d;
      logic [15:0] f0, ef;
      logic [23:0] pc0, vec;
      logic [1:0] r;
      logic slp, idl, en;
      rcr_cause_t ce;
      rcr_events_t ev;
      f0 = 16'($random(seed));
      pc0 = 24'($random(seed)) & 24'hfffffe;
      vec = 24'($random(seed)) & 24'hfffffe;
      en = 1'($random(seed));
      axi_write(OFS_CAUSE, {16'h0000, f0}, 4'h3, r);
      ev = ev_of(c);
      for (int k = int'(c) + 1; k < 13; k++)
         if (noisy && c != CAUSE_NONE && $random(seed) % 3 == 0)
            ev = ev | ev_of(rcr_cause_t'(k));
      slp = 1'($random(seed));
      if (c inside {CAUSE_EXT_SLEEP, CAUSE_WDT_WAKE})
         slp = 1'b1;
      if (c inside {CAUSE_EXT_RUN, CAUSE_EXT_IDLE, CAUSE_WDT_RESET})
         slp = 1'b0;
      if (c == CAUSE_IRQ_WAKE && !noisy)
         slp = 1'b1;
      idl = (c == CAUSE_EXT_IDLE) ? 1'b1 : 1'($random(seed));
      if (c == CAUSE_EXT_RUN)
         idl = 1'b0;
      ce = (c == CAUSE_IRQ_WAKE && !slp) ? CAUSE_NONE : c;
      @(posedge aclk);
      events <= ev;
      cpu_sleeping <= slp;
      cpu_idling <= idl;
      cur_pc <= pc0;
      irq_vector <= vec;
      irq_enabled <= en;
      @(posedge aclk);
      events <= '0;
      #1;
      mk = masks(ce);
      ef = (f0 & ~mk[15:0]) | mk[31:16];
      case (ce)
         CAUSE_NONE: ;
         CAUSE_CLK_FAIL: exp_pc = PC_CLKFAIL_VEC;
         CAUSE_WDT_WAKE: exp_pc = pc0 + PC_NEXT_STEP;
         CAUSE_IRQ_WAKE: exp_pc = en ? vec : pc0 + PC_NEXT_STEP;
         default: exp_pc = PC_RESET_VEC;
      endcase
      chk_bit(pc_load, ce != CAUSE_NONE);
      chk(32'(pc_value), 32'(exp_pc));
      chk(32'(reset_cause_control), 32'(ef));
      @(posedge aclk);
      #1;
      chk_bit(pc_load, 1'b0);
      axi_read(OFS_CAUSE, d, r);
      chk(d, 32'(ef));
      if (ce == CAUSE_POWER_ON)
         chk(d & 32'h2, 32'h2);
      if (ce != CAUSE_NONE)
      begin
         axi_read(OFS_STATUS, d, r);
         chk(d, 32'(ce));
      end
      axi_read(OFS_PC, d, r);
      chk(d, 32'(exp_pc));
   endtask : run_case

   // Main sequence
   initial
   begin
      logic [31:0] d;
      logic [1:0] r;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, cpu_sleeping, cpu_idling} = '0;
      {events, irq_enabled, irq_vector, cur_pc} = '0;
      exp_pc = PC_RESET_VEC;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      chk(32'(reset_cause_control), 32'(FLAGS_RESET));
      chk(32'(pc_value), 32'h0);
      chk_bit(pc_load, 1'b0);
      // Byte strobes, read-only and unmapped places
      axi_write(OFS_CAUSE, 32'hffff_a5c3, 4'h1, r);
      chk(32'(r), 32'(RESP_OKAY));
      axi_write(OFS_CAUSE, 32'h0000_5a00, 4'h2, r);
      axi_write(OFS_STATUS, 32'h0000_000f, 4'hf, r);
      chk(32'(r), 32'(RESP_OKAY));
      axi_write(12'h010, 32'hffff_ffff, 4'hf, r);
      chk(32'(r), 32'(RESP_SLVERR));
      axi_read(OFS_CAUSE, d, r);
      chk(d, 32'h0000_5ac3);
      axi_read(OFS_STATUS, d, r);
      chk(d, 32'(CAUSE_NONE));
      axi_read(12'h010, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(d, 32'h0);
      // Every cause once, then random causes with coinciding strobes
      for (int i = 0; i < 70; i++)
         run_case(i < 13 ? rcr_cause_t'(i)
            : rcr_cause_t'(unsigned'($random(seed)) % 13), i >= 13);
      // Software reset command through the control register
      axi_write(OFS_CAUSE, 32'h0000_ffff, 4'h3, r);
      axi_write(OFS_CONTROL, 32'h0000_0001, 4'hf, r);
      repeat (3) @(posedge aclk);
      #1;
      d = masks(CAUSE_SOFTWARE);
      chk(32'(reset_cause_control), 32'((16'hffff & ~d[15:0]) | d[31:16]));
      chk(32'(pc_value), 32'(PC_RESET_VEC));
      axi_read(OFS_STATUS, d, r);
      chk(d, 32'(CAUSE_SOFTWARE));
      // Second reset in mid-run
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      chk(32'(reset_cause_control), 32'(FLAGS_RESET));
      chk(32'(pc_value), 32'h0);
      results();
   end

   // Watchdog on a hung run
   initial
   begin
      #400000;
      num_errors++;
      $display("ERROR t=%0t run too long got=%h exp=%h", $time, 1, 0);
      results();
   end
endmodule : tb_rcr_reset_cause_recorder
